// ===== dv/frame_source.sv
// subscriber-side model that presents frame headers to the classifier
`timescale 1ns/10ps
module frame_source
   import cos_class_pkg::*;
(
   // clock
   input  wire logic               clk_i,
   // header fields toward the classifier
   output logic                    valid_o,
   output logic      [15:0]        tci_o,
   output logic                    has_ctag_o,
   output logic      [7:0]         tos_o,
   output logic                    ipv4_o,
   output logic                    ipv6_o,
   output logic                    ctrl_o,
   output logic      [PROTO_W-1:0] proto_o
);
   // quiet line at time zero
   initial begin
      valid_o = 1'b0;
      {tci_o, has_ctag_o, tos_o, ipv4_o, ipv6_o, ctrl_o, proto_o} = '0;
   end

   // one header for one cycle; idle lines show inverted junk so stale fields never pass
   task automatic send(input logic t, input logic [2:0] p, input logic a, input logic b,
                       input logic [5:0] d, input logic c, input logic [PROTO_W-1:0] q);
      @(posedge clk_i);
      #1;
      valid_o = 1'b1;
      {tci_o, has_ctag_o, tos_o, ipv4_o, ipv6_o, ctrl_o, proto_o} = {p, 13'h0abc, t, d, 2'h1, a, b, c, q};
      @(posedge clk_i);
      #1;
      valid_o = 1'b0;
      {tci_o, has_ctag_o, tos_o, ipv4_o, ipv6_o, ctrl_o, proto_o} = ~{tci_o, has_ctag_o, tos_o, ipv4_o,
                                                                      ipv6_o, ctrl_o, proto_o};
   endtask
endmodule // frame_source

// ===== dv/ingress_cos_classifier_tb.sv
// self-checking bench for the ingress class-of-service classifier
`timescale 1ns/10ps
module ingress_cos_classifier_tb;
   import cos_class_pkg::*;
   // bench-driven configuration
   logic clk = 1'b0, srst = 1'b1, load = 1'b0, wr = 1'b0, hit = 1'b0;
   logic [2:0] basis = 3'h1;
   logic [CLASS_W-1:0] ep = 4'h1, nip = 4'h1, ut = 4'h1, tcls = 4'h0;
   logic [1:0] sel = 2'h0;
   logic [5:0] idx = 6'h00;
   // headers from the model and results
   logic fv, tag, v4, v6, ctl, vld, drop, fwd, rej;
   logic [15:0] tci;
   logic [7:0] tos;
   logic [PROTO_W-1:0] pr;
   logic [CLASS_W-1:0] cls;
   logic [2:0] bas;
   int fails = 0, n_checks = 0, cycles = 0;

   always #4 clk = ~clk;

   frame_source frame_source_i (.clk_i(clk), .valid_o(fv), .tci_o(tci), .has_ctag_o(tag), .tos_o(tos),
      .ipv4_o(v4), .ipv6_o(v6), .ctrl_o(ctl), .proto_o(pr));
   ingress_cos_classifier ingress_cos_classifier_i (.CLOCK_I(clk), .SRST_I(srst), .BASIS_I(basis),
      .EP_CLASS_I(ep), .NONIP_CLASS_I(nip), .UNTAG_CLASS_I(ut), .CFG_LOAD_I(load), .TBL_WR_I(wr),
      .TBL_SEL_I(sel), .TBL_IDX_I(idx), .TBL_CLASS_I(tcls), .TBL_HIT_I(hit), .FRAME_VALID_I(fv),
      .CTAG_TCI_I(tci), .HAS_CTAG_I(tag), .IP_TOS_I(tos), .IS_IPV4_I(v4), .IS_IPV6_I(v6),
      .IS_CTRL_I(ctl), .CTRL_PROTO_I(pr), .CLASS_VALID_O(vld), .CLASS_O(cls), .DROP_O(drop),
      .FORWARD_O(fwd), .BASIS_O(bas), .CFG_REJECT_O(rej));

   task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one load pulse; reject flag and selector judged a cycle on
   task automatic cfg(input logic [2:0] b, input logic [3:0] e, input logic [3:0] n, input logic [3:0] u,
                      input logic rj, input logic [2:0] bx);
      @(posedge clk);
      #1;
      {basis, ep, nip, ut, load} = {b, e, n, u, 1'b1};
      @(posedge clk);
      #1;
      load = 1'b0;
      chk_val("cfg_reject", 8'(rj), 8'(rej));
      chk_val("basis", 8'(bx), 8'(bas));
   endtask

   task automatic tbl(input logic [1:0] s, input logic [5:0] i, input logic [3:0] c, input logic h);
      @(posedge clk);
      #1;
      {sel, idx, tcls, hit, wr} = {s, i, c, h, 1'b1};
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask

   // verdict stands one cycle, so it is judged right after the model's frame
   task automatic frame(input logic t, input logic [2:0] p, input logic a, input logic b, input logic [5:0] d,
                        input logic c, input logic [3:0] q, input logic [3:0] x);
      frame_source_i.send(t, p, a, b, d, c, q);
      chk_val("class_valid", 8'h01, 8'(vld));
      chk_val("class", 8'(x), 8'(cls));
      chk_val("drop", 8'(x == DISCARD_CLASS), 8'(drop));
      chk_val("forward", 8'(x != DISCARD_CLASS), 8'(fwd));
   endtask

   task automatic t_endpoint();
      cfg(BASIS_ENDPOINT, 4'h5, 4'h1, 4'h1, 1'b0, 3'h1);
      frame(1'b1, 3'h3, 1'b1, 1'b0, 6'h25, 1'b0, 4'h0, 4'h5);
      frame(1'b0, 3'h0, 1'b0, 1'b0, 6'h00, 1'b1, 4'h4, 4'h5);
      cfg(BASIS_ENDPOINT, DISCARD_CLASS, 4'h1, 4'h1, 1'b1, 3'h1);
      frame(1'b1, 3'h7, 1'b0, 1'b1, 6'h3f, 1'b0, 4'h0, 4'h5);
      $display("test endpoint done");
   endtask

   // pcp 1 lands on the discard class
   task automatic t_pcp();
      for (int i = 0; i < N_PCP; i++)
         tbl(TBL_PCP, 6'(i), 4'(i) ^ 4'h1, 1'b0);
      cfg(BASIS_PCP, 4'h5, 4'h1, 4'h7, 1'b0, 3'h2);
      for (int i = 0; i < N_PCP; i++)
         frame(1'b1, 3'(i), 1'b0, 1'b0, 6'h00, 1'b0, 4'h0, 4'(i) ^ 4'h1);
      frame(1'b0, 3'h1, 1'b1, 1'b0, 6'h00, 1'b0, 4'h0, 4'h7);
      // discard endpoint class is legal while another basis is active
      cfg(BASIS_PCP, DISCARD_CLASS, 4'h1, 4'h1, 1'b0, 3'h2);
      frame(1'b1, 3'h0, 1'b0, 1'b0, 6'h00, 1'b0, 4'h0, 4'h1);
      frame(1'b0, 3'h5, 1'b0, 1'b0, 6'h00, 1'b0, 4'h0, 4'h1);
      $display("test pcp done");
   endtask

   task automatic t_dscp();
      tbl(TBL_V4, 6'h25, 4'h3, 1'b0);
      tbl(TBL_V6, 6'h25, 4'h6, 1'b0);
      tbl(TBL_V6, 6'h0b, DISCARD_CLASS, 1'b0);
      cfg(BASIS_DSCP, 4'h5, 4'h9, 4'h7, 1'b0, 3'h4);
      frame(1'b1, 3'h0, 1'b1, 1'b0, 6'h25, 1'b0, 4'h0, 4'h3);
      frame(1'b0, 3'h0, 1'b1, 1'b1, 6'h25, 1'b0, 4'h0, 4'h3);
      frame(1'b0, 3'h0, 1'b0, 1'b1, 6'h25, 1'b0, 4'h0, 4'h6);
      frame(1'b0, 3'h0, 1'b0, 1'b1, 6'h0b, 1'b0, 4'h0, DISCARD_CLASS);
      frame(1'b1, 3'h5, 1'b0, 1'b0, 6'h25, 1'b0, 4'h0, 4'h9);
      cfg(3'h3, 4'h5, 4'h2, 4'h7, 1'b1, 3'h4);
      frame(1'b0, 3'h0, 1'b0, 1'b0, 6'h25, 1'b0, 4'h0, 4'h9);
      $display("test dscp done");
   endtask

   task automatic t_ctrl();
      tbl(TBL_CTRL, 6'h02, 4'hb, 1'b1);
      frame(1'b0, 3'h0, 1'b1, 1'b0, 6'h25, 1'b1, 4'h2, 4'hb);
      frame(1'b0, 3'h0, 1'b1, 1'b0, 6'h25, 1'b1, 4'h3, 4'h3);
      frame(1'b0, 3'h0, 1'b1, 1'b0, 6'h25, 1'b0, 4'h2, 4'h3);
      tbl(TBL_CTRL, 6'h02, 4'hb, 1'b0);
      frame(1'b0, 3'h0, 1'b1, 1'b0, 6'h25, 1'b1, 4'h2, 4'h3);
      $display("test control done");
   endtask

   // mid-run reset: selector, reject flag and control map return to reset state
   task automatic t_reset();
      tbl(TBL_CTRL, 6'h02, 4'hb, 1'b1);
      @(posedge clk);
      #1;
      srst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      srst = 1'b0;
      chk_val("cfg_reject", 8'h00, 8'(rej));
      chk_val("basis", 8'h01, 8'(bas));
      frame(1'b0, 3'h0, 1'b1, 1'b0, 6'h25, 1'b1, 4'h2, RESET_CLASS);
      $display("test reset done");
   endtask

   // reset, then the scenarios in turn
   initial begin
      repeat (10) @(posedge clk);
      #1;
      srst = 1'b0;
      chk_val("basis", 8'h01, 8'(bas));
      chk_val("class_valid", 8'h00, 8'(vld));
      chk_val("class", 8'h00, 8'(cls));
      chk_val("drop", 8'h00, 8'(drop));
      chk_val("forward", 8'h00, 8'(fwd));
      chk_val("cfg_reject", 8'h00, 8'(rej));
      t_endpoint();
      t_pcp();
      t_dscp();
      t_ctrl();
      t_reset();
      complete_run();
   end

   // hang guard, far above the hundred or so cycles the scenarios need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         complete_run();
      end
   end
endmodule // ingress_cos_classifier_tb

// ===== hw/cos_class_pkg.sv
// constants and types for the ingress class-of-service classifier
// Operation
// (R1) plain data frames take class from map
// (R2) endpoint basis: one class for all frames; control frames with a map entry take that entry instead
// (R3) endpoint basis class never Discard; rejected
// (R4) pcp basis: class per PCP plus untagged
// (R5) untagged should match PCP 0 class; untagged class is loaded separately, not tied to PCP 0
// (R6) dscp basis: separate IPv4 and IPv6 tables
// (R7) IPv4 and IPv6 tables programmed independently
// (R8) dscp basis: non-IP frames get one class
// (R9) control frame with map entry uses it
// (R10) control frame without entry classed as data
// (R11) SOAM-only frames classed as data
// (R12) Discard class frames are dropped
// (R13) selector is endpoint, PCP or DSCP
// (R14) control map keyed by protocol type, sparse
// (R15) extract PCP, DSCP; output class index
package cos_class_pkg;
   localparam int CLASS_W = 4;
   localparam int PCP_W   = 3;
   localparam int DSCP_W  = 6;
   localparam int PROTO_W = 4;
   localparam int N_PCP   = 8;
   localparam int N_DSCP  = 64;
   localparam int N_PROTO = 16;
   localparam logic [CLASS_W-1:0] DISCARD_CLASS = 4'h0;
   localparam logic [CLASS_W-1:0] RESET_CLASS   = 4'h1;
   localparam logic [1:0] TBL_PCP  = 2'h0;
   localparam logic [1:0] TBL_V4   = 2'h1;
   localparam logic [1:0] TBL_V6   = 2'h2;
   localparam logic [1:0] TBL_CTRL = 2'h3;

   typedef enum logic [2:0] {
      BASIS_ENDPOINT = 3'b001,
      BASIS_PCP      = 3'b010,
      BASIS_DSCP     = 3'b100
   } basis_t;

   // header fields already pulled from the frame
   typedef struct packed {
      logic               has_ctag;
      logic [PCP_W-1:0]   pcp;
      logic               is_ipv4;
      logic               is_ipv6;
      logic [DSCP_W-1:0]  dscp;
      logic               is_ctrl;
      logic [PROTO_W-1:0] proto;
   } frame_hdr_t;

   // classifier verdict
   typedef struct packed {
      logic               valid;
      logic [CLASS_W-1:0] cls;
      logic               drop;
   } verdict_t;

   // raw tag and IP header bytes as seen on the frame
   function automatic logic [PCP_W-1:0] tci_pcp(input logic [15:0] tci);
      return tci[15:13];
   endfunction

   function automatic logic [DSCP_W-1:0] tos_dscp(input logic [7:0] tos);
      return tos[7:2];
   endfunction
endpackage

// ===== hw/cos_map_tables.sv
// programmable class tables: pcp, ipv4, ipv6 and control protocol map
`timescale 1ns/10ps
module cos_map_tables
   import cos_class_pkg::*;
(
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               srst_i,
   // table write port
   input  wire logic               wr_en_i,
   input  wire logic [1:0]         wr_tbl_i,
   input  wire logic [5:0]         wr_idx_i,
   input  wire logic [CLASS_W-1:0] wr_cls_i,
   input  wire logic               wr_hit_i,
   // lookups
   input  wire logic [PCP_W-1:0]   pcp_i,
   input  wire logic [DSCP_W-1:0]  dscp_i,
   input  wire logic [PROTO_W-1:0] proto_i,
   output logic      [CLASS_W-1:0] pcp_cls_o,
   output logic      [CLASS_W-1:0] v4_cls_o,
   output logic      [CLASS_W-1:0] v6_cls_o,
   output logic      [CLASS_W-1:0] ctrl_cls_o,
   output logic                    ctrl_hit_o
);
   logic [CLASS_W-1:0] pcp_mem  [N_PCP];
   logic [CLASS_W-1:0] v4_mem   [N_DSCP];
   logic [CLASS_W-1:0] v6_mem   [N_DSCP];
   logic [CLASS_W-1:0] ctrl_mem [N_PROTO];
   logic [N_PROTO-1:0] ctrl_hit_reg;

   // separate ipv4 and ipv6 arrays so each dscp maps independently
   always_ff @(posedge clk_i) begin
      if (wr_en_i && wr_tbl_i == TBL_PCP) pcp_mem[wr_idx_i[PCP_W-1:0]] <= wr_cls_i; // R4
      if (wr_en_i && wr_tbl_i == TBL_V4) v4_mem[wr_idx_i] <= wr_cls_i; // R7
      if (wr_en_i && wr_tbl_i == TBL_V6) v6_mem[wr_idx_i] <= wr_cls_i; // R7
      if (wr_en_i && wr_tbl_i == TBL_CTRL) ctrl_mem[wr_idx_i[PROTO_W-1:0]] <= wr_cls_i;
   end

   // control map starts empty; an entry exists only once written with hit set
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_hit_reg <= '0; // R14
      end else if (wr_en_i && wr_tbl_i == TBL_CTRL) begin
         ctrl_hit_reg[wr_idx_i[PROTO_W-1:0]] <= wr_hit_i; // R14
      end
   end

   // combinational reads
   assign pcp_cls_o  = pcp_mem[pcp_i];
   assign v4_cls_o   = v4_mem[dscp_i];
   assign v6_cls_o   = v6_mem[dscp_i];
   assign ctrl_cls_o = ctrl_mem[proto_i];
   assign ctrl_hit_o = ctrl_hit_reg[proto_i];
endmodule // cos_map_tables

// ===== hw/ingress_cos_classifier.sv
// ingress class-of-service classifier for one service endpoint
`timescale 1ns/10ps
module ingress_cos_classifier
   import cos_class_pkg::*;
(
   // clock and reset
   input  wire logic               CLOCK_I,
   input  wire logic               SRST_I,
   // configuration
   input  wire logic [2:0]         BASIS_I,
   input  wire logic [CLASS_W-1:0] EP_CLASS_I,
   input  wire logic [CLASS_W-1:0] NONIP_CLASS_I,
   input  wire logic [CLASS_W-1:0] UNTAG_CLASS_I,
   input  wire logic               CFG_LOAD_I,
   input  wire logic               TBL_WR_I,
   input  wire logic [1:0]         TBL_SEL_I,
   input  wire logic [5:0]         TBL_IDX_I,
   input  wire logic [CLASS_W-1:0] TBL_CLASS_I,
   input  wire logic               TBL_HIT_I,
   // frame headers
   input  wire logic               FRAME_VALID_I,
   input  wire logic [15:0]        CTAG_TCI_I,
   input  wire logic               HAS_CTAG_I,
   input  wire logic [7:0]         IP_TOS_I,
   input  wire logic               IS_IPV4_I,
   input  wire logic               IS_IPV6_I,
   input  wire logic               IS_CTRL_I,
   input  wire logic [PROTO_W-1:0] CTRL_PROTO_I,
   // results
   output logic                    CLASS_VALID_O,
   output logic      [CLASS_W-1:0] CLASS_O,
   output logic                    DROP_O,
   output logic                    FORWARD_O,
   output logic      [2:0]         BASIS_O,
   output logic                    CFG_REJECT_O
);
   basis_t             basis_reg;
   logic [CLASS_W-1:0] ep_class_reg;
   logic [CLASS_W-1:0] nonip_class_reg;
   logic [CLASS_W-1:0] untag_class_reg;
   logic               reject_reg;
   verdict_t           verdict_reg;
   verdict_t           verdict_next;
   frame_hdr_t         hdr;
   logic [CLASS_W-1:0] pcp_cls;
   logic [CLASS_W-1:0] v4_cls;
   logic [CLASS_W-1:0] v6_cls;
   logic [CLASS_W-1:0] ctrl_cls;
   logic               ctrl_hit;
   logic [CLASS_W-1:0] data_cls;
   logic [CLASS_W-1:0] dscp_cls;
   logic [CLASS_W-1:0] tag_cls;
   logic [CLASS_W-1:0] final_cls;
   logic               basis_ok;
   logic               ep_bad;
   logic               forward_next;
   logic               forward_reg;

   // header fields gathered from the frame
   assign hdr.has_ctag = HAS_CTAG_I;
   assign hdr.pcp      = tci_pcp(CTAG_TCI_I); // R15
   assign hdr.is_ipv4  = IS_IPV4_I;
   assign hdr.is_ipv6  = IS_IPV6_I;
   assign hdr.dscp     = tos_dscp(IP_TOS_I); // R15
   assign hdr.is_ctrl  = IS_CTRL_I;
   assign hdr.proto    = CTRL_PROTO_I;

   cos_map_tables cos_map_tables_i (
      .clk_i      (CLOCK_I),
      .srst_i     (SRST_I),
      .wr_en_i    (TBL_WR_I),
      .wr_tbl_i   (TBL_SEL_I),
      .wr_idx_i   (TBL_IDX_I),
      .wr_cls_i   (TBL_CLASS_I),
      .wr_hit_i   (TBL_HIT_I),
      .pcp_i      (hdr.pcp),
      .dscp_i     (hdr.dscp),
      .proto_i    (hdr.proto),
      .pcp_cls_o  (pcp_cls),
      .v4_cls_o   (v4_cls),
      .v6_cls_o   (v6_cls),
      .ctrl_cls_o (ctrl_cls),
      .ctrl_hit_o (ctrl_hit)
   );

   // configuration checks: only three legal selector codes, endpoint class not discard
   assign basis_ok = (BASIS_I == BASIS_ENDPOINT) || (BASIS_I == BASIS_PCP)
                     || (BASIS_I == BASIS_DSCP); // R13
   assign ep_bad   = (BASIS_I == BASIS_ENDPOINT) && (EP_CLASS_I == DISCARD_CLASS); // R3

   // rejected loads leave the previous config in force
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         basis_reg       <= BASIS_ENDPOINT;
         ep_class_reg    <= RESET_CLASS;
         nonip_class_reg <= RESET_CLASS;
         untag_class_reg <= RESET_CLASS;
         reject_reg      <= 1'b0;
      end else if (CFG_LOAD_I) begin
         reject_reg <= !basis_ok || ep_bad; // R3
         if (basis_ok && !ep_bad) begin
            basis_reg       <= basis_t'(BASIS_I); // R13
            ep_class_reg    <= EP_CLASS_I; // R2
            nonip_class_reg <= NONIP_CLASS_I; // R8
            untag_class_reg <= UNTAG_CLASS_I; // R4
         end
      end
   end

   // untagged class kept separately; software sets it equal to pcp 0 if desired
   assign tag_cls  = hdr.has_ctag ? pcp_cls : untag_class_reg; // R4 R5
   // ipv6 wins only when ipv4 is not flagged; neither means non-ip
   assign dscp_cls = hdr.is_ipv4 ? v4_cls : (hdr.is_ipv6 ? v6_cls : nonip_class_reg); // R6 R8
   // data class from the selected basis; SOAM frames arrive as plain data
   assign data_cls = (basis_reg == BASIS_PCP)  ? tag_cls :
                     (basis_reg == BASIS_DSCP) ? dscp_cls : ep_class_reg; // R1 R2 R11
   // control frames use their map entry, else fall through to data rules
   assign final_cls = (hdr.is_ctrl && ctrl_hit) ? ctrl_cls : data_cls; // R9 R10

   // verdict assembly
   always_comb begin
      verdict_next.valid = FRAME_VALID_I;
      verdict_next.cls   = final_cls; // R15
      verdict_next.drop  = FRAME_VALID_I && (final_cls == DISCARD_CLASS); // R12
   end

   // forward kept in its own flop so no gate sits between register and pin
   assign forward_next = FRAME_VALID_I && (final_cls != DISCARD_CLASS); // R12

   // one-cycle registered result
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         verdict_reg <= '0;
         forward_reg <= 1'b0;
      end else begin
         verdict_reg <= verdict_next;
         forward_reg <= forward_next;
      end
   end

   // outputs straight from flip-flops
   assign CLASS_VALID_O = verdict_reg.valid;
   assign CLASS_O       = verdict_reg.cls;
   assign DROP_O        = verdict_reg.drop;
   assign FORWARD_O     = forward_reg; // R12
   assign BASIS_O       = basis_reg;
   assign CFG_REJECT_O  = reject_reg;

   // config load steps shared by the checks below
   sequence legal_load_s;
      CFG_LOAD_I && basis_ok && !ep_bad;
   endsequence
   sequence illegal_load_s;
      CFG_LOAD_I && !basis_ok;
   endsequence
   // a refused load must leave selector and endpoint class untouched
   sequence kept_cfg_s;
      CFG_REJECT_O && $stable(basis_reg) && $stable(ep_class_reg);
   endsequence

   // configuration checks
   chk_ep_never_discard: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R3
      basis_reg == BASIS_ENDPOINT |-> ep_class_reg != DISCARD_CLASS)
      else $error("endpoint class became discard");
   chk_reject_bad_cfg: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R3
      CFG_LOAD_I && ep_bad |=> kept_cfg_s)
      else $error("bad endpoint config accepted");
   chk_reject_bad_basis: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R13
      illegal_load_s |=> kept_cfg_s)
      else $error("illegal selector accepted");
   chk_accept_good_cfg: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R13
      legal_load_s |=> !CFG_REJECT_O && BASIS_O == $past(BASIS_I))
      else $error("legal config not taken");
   chk_basis_legal: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R13
      basis_reg inside {BASIS_ENDPOINT, BASIS_PCP, BASIS_DSCP})
      else $error("illegal basis held");

   // frame class checks; table reads taken one cycle back, as the verdict flop saw them
   chk_ep_class_out: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R2
      FRAME_VALID_I && !IS_CTRL_I && basis_reg == BASIS_ENDPOINT |=> CLASS_O == $past(ep_class_reg))
      else $error("endpoint class not applied");
   chk_tagged_pcp: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R4
      FRAME_VALID_I && !IS_CTRL_I && HAS_CTAG_I && basis_reg == BASIS_PCP
      |=> CLASS_O == $past(pcp_cls))
      else $error("tagged class wrong");
   chk_untag_class: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R4
      FRAME_VALID_I && !IS_CTRL_I && !HAS_CTAG_I && basis_reg == BASIS_PCP
      |=> CLASS_O == $past(untag_class_reg))
      else $error("untagged class wrong");
   chk_v4_table: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R6
      FRAME_VALID_I && !IS_CTRL_I && IS_IPV4_I && basis_reg == BASIS_DSCP
      |=> CLASS_O == $past(v4_cls))
      else $error("ipv4 class wrong");
   chk_both_ip: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R6
      FRAME_VALID_I && !IS_CTRL_I && IS_IPV4_I && IS_IPV6_I && basis_reg == BASIS_DSCP
      |=> CLASS_O == $past(v4_cls))
      else $error("ipv4 did not win over ipv6");
   chk_v6_table: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R7
      FRAME_VALID_I && !IS_CTRL_I && !IS_IPV4_I && IS_IPV6_I && basis_reg == BASIS_DSCP
      |=> CLASS_O == $past(v6_cls))
      else $error("ipv6 class wrong");
   chk_nonip_class: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R8
      FRAME_VALID_I && !IS_CTRL_I && !IS_IPV4_I && !IS_IPV6_I && basis_reg == BASIS_DSCP
      |=> CLASS_O == $past(nonip_class_reg))
      else $error("non-ip class wrong");
   chk_ctrl_hit: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R9
      FRAME_VALID_I && IS_CTRL_I && ctrl_hit |=> CLASS_O == $past(ctrl_cls))
      else $error("control map entry ignored");
   chk_ctrl_miss: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R10
      FRAME_VALID_I && IS_CTRL_I && !ctrl_hit |=> CLASS_O == $past(data_cls))
      else $error("control miss not classed as data");

   // verdict flag checks
   chk_discard_drops: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R12
      FRAME_VALID_I && final_cls == DISCARD_CLASS |=> DROP_O && !FORWARD_O)
      else $error("discard class not dropped");
   chk_forward_flag: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R12
      CLASS_VALID_O |-> FORWARD_O == !DROP_O)
      else $error("forward and drop disagree");
   chk_valid_latency: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R1
      FRAME_VALID_I |=> CLASS_VALID_O)
      else $error("verdict missing");
   chk_valid_pulse: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // R1
      !FRAME_VALID_I |=> !CLASS_VALID_O && !DROP_O && !FORWARD_O)
      else $error("verdict without a frame");
endmodule // ingress_cos_classifier
